//--- logic/csd_pkg.sv
// Purpose: shared constants and types for the stop/debug/operand core
// Assumes: 40 MHz system clock, AXI4-Lite register access
// Notes: one aligned 32-bit word per register
// Function
// - Debug enable keeps oscillator running in stop
// - Halt command in stop restarts clocks, background
// - Optional minimal clocks allow periodic wake
// - Background-entry opcode halts user execution
// - Only reset or resume commands restart program
// - Breakpoint opcode at address forces background; not implemented in csd_core
// - Flags: V7 H4 I3 N2 Z1 C0
// - Carry is carry out of bit 7
// - Sixteen-bit value: high byte first
// - Direct operand gives low byte, high zero
// - Branch offset signed, from next address
// - Bit index limited to zero through seven
// - Short indexed offset zero-extended
// - Long indexed offset adds modulo 64K
// - Extended address high byte then low
// - Post-increment modes limited to compare/move
// - Index or stack base plus offset
// - Immediate sixteen-bit high byte first
// - Immediate high fetched after opcode, then low
// - Post-increment adds one after fetch
package csd_pkg;
   // Register byte offsets
   localparam logic [7:0] CSD_CTRL_OFS = 8'h00;
   localparam logic [7:0] CSD_STAT_OFS = 8'h04;
   localparam logic [7:0] CSD_FLAGS_OFS = 8'h08;
   localparam logic [7:0] CSD_OPND_OFS = 8'h0C;
   localparam logic [7:0] CSD_BASE_OFS = 8'h10;
   localparam logic [7:0] CSD_EA_OFS = 8'h14;
   // Control fields
   localparam int CSD_CTRL_ENBG_POS = 0;
   localparam int CSD_CTRL_MINCLK_POS = 1;
   localparam int CSD_CTRL_STOP_POS = 2;
   localparam int CSD_CTRL_RESETBG_POS = 3;
   // Condition flag positions
   localparam int CSD_FLAG_V_POS = 7;
   localparam int CSD_FLAG_H_POS = 4;
   localparam int CSD_FLAG_I_POS = 3;
   localparam int CSD_FLAG_N_POS = 2;
   localparam int CSD_FLAG_Z_POS = 1;
   localparam int CSD_FLAG_C_POS = 0;
   localparam logic [7:0] CSD_FLAGS_RST = 8'h08;
   localparam logic [7:0] CSD_BACKGROUND_ENTRY_INSTRUCTION_OPC = 8'h82;
   localparam logic [15:0] CSD_ONE = 16'h0001;
   localparam logic [1:0] CSD_RESP_OK = 2'h0;
   localparam logic [1:0] CSD_RESP_SLVERR = 2'h2;
   // Addressing modes
   typedef enum logic [3:0] {
      AM_IMM8, AM_IMM16, AM_DIR, AM_EXT, AM_IX, AM_IXP, AM_IX1,
      AM_IX1P, AM_IX2, AM_SP1, AM_SP2, AM_REL
   } csd_mode_type;
   // Instruction classes for post-increment legality
   typedef enum logic [1:0] {
      IC_OTHER, IC_CMPBR, IC_MOVE
   } csd_iclass_type;
   // Serial debug commands
   typedef enum logic [2:0] {
      DC_NONE, DC_HALT, DC_GO, DC_TRACE, DC_TAG_RESUME_COMMAND, DC_SETEN
   } csd_dcmd_type;
   // Core run states
   typedef enum logic [1:0] {
      RS_RUN, RS_STOP, RS_BKG
   } csd_run_type;
   // Operand decode request
   typedef struct packed {
      csd_mode_type mode;
      csd_iclass_type iclass;
      logic [7:0] b1;
      logic [7:0] b2;
      logic [15:0] pc_next;
      logic [2:0] bitn;
   } csd_opreq_type;
   // Operand decode result
   typedef struct packed {
      logic [15:0] ea;
      logic [15:0] imm;
      logic illegal;
      logic postinc;
      logic [7:0] bitmask;
   } csd_opres_type;
endpackage : csd_pkg

//--- logic/csd_opdec.sv
// Purpose: combinational operand and effective-address former
// Assumes: operand bytes already fetched in object-code order
// Notes: pure logic, no state
module csd_opdec (
   input wire csd_pkg::csd_opreq_type req_in,
   input wire logic [15:0] index_in,
   input wire logic [15:0] stack_in,
   output csd_pkg::csd_opres_type res_out
);
   import csd_pkg::*;

   // Two object bytes form a word, first byte is the high half
   function automatic logic [15:0] join_hl(input logic [7:0] h,
                                           input logic [7:0] l);
      join_hl = {h, l};
   endfunction : join_hl

   // Mode-dependent address arithmetic
   always_comb begin
      res_out = '0;
      res_out.bitmask = 8'h01 << req_in.bitn;
      case (req_in.mode)
         AM_IMM8: res_out.imm = {8'h00, req_in.b1};
         AM_IMM16: res_out.imm = join_hl(req_in.b1, req_in.b2);
         AM_DIR: res_out.ea = {8'h00, req_in.b1};
         AM_EXT: res_out.ea = join_hl(req_in.b1, req_in.b2);
         AM_IX: res_out.ea = index_in;
         AM_IXP: begin
            res_out.ea = index_in;
            res_out.postinc = 1'b1;
            res_out.illegal = req_in.iclass == IC_OTHER;
         end
         AM_IX1: res_out.ea = index_in + {8'h00, req_in.b1};
         AM_IX1P: begin
            res_out.ea = index_in + {8'h00, req_in.b1};
            res_out.postinc = 1'b1;
            res_out.illegal = req_in.iclass != IC_CMPBR;
         end
         // Wraps naturally at 16 bits, sign makes no difference
         AM_IX2: res_out.ea = index_in + join_hl(req_in.b1, req_in.b2);
         AM_SP1: res_out.ea = stack_in + {8'h00, req_in.b1};
         AM_SP2: res_out.ea = stack_in + join_hl(req_in.b1, req_in.b2);
         // Sign-extended from the address after the last byte
         AM_REL: res_out.ea = req_in.pc_next
            + {{8{req_in.b1[7]}}, req_in.b1};
         default: res_out.illegal = 1'b1;
      endcase
   end
endmodule : csd_opdec

//--- logic/csd_core.sv
// Purpose: stop/background control, flags and operand decode registers
// Assumes: serial command decoder supplies one-cycle command pulses
// Notes: AXI4-Lite slave, one write and one read outstanding
//
// Our own choices: the AXI4-Lite interface to the registers and the address map.
module csd_core (
   input wire logic SYS_CLK_IN,
   input wire logic RST_B_IN,
   // AXI4-Lite slave
   input wire logic [7:0] AWADDR_IN,
   input wire logic AWVALID_IN,
   output logic AWREADY_OUT,
   input wire logic [31:0] WDATA_IN,
   input wire logic [3:0] WSTRB_IN,
   input wire logic WVALID_IN,
   output logic WREADY_OUT,
   output logic [1:0] BRESP_OUT,
   output logic BVALID_OUT,
   input wire logic BREADY_IN,
   input wire logic [7:0] ARADDR_IN,
   input wire logic ARVALID_IN,
   output logic ARREADY_OUT,
   output logic [31:0] RDATA_OUT,
   output logic [1:0] RRESP_OUT,
   output logic RVALID_OUT,
   input wire logic RREADY_IN,
   // Debug link commands, decoded from the debug pin
   input wire csd_pkg::csd_dcmd_type DBG_CMD_IN,
   // Core events
   input wire logic OPCODE_VALID_IN,
   input wire logic [7:0] OPCODE_IN,
   input wire logic STOP_EXEC_IN,
   input wire logic PERIODIC_WAKE_IN,
   input wire logic EXT_WAKE_IN,
   // Arithmetic flag source
   input wire logic ALU_VALID_IN,
   input wire logic [7:0] ALU_A_IN,
   input wire logic [7:0] ALU_B_IN,
   input wire logic ALU_SUB_IN,
   // Clock and mode outputs
   output logic OSC_ON_OUT,
   output logic CORE_CLK_EN_OUT,
   output logic MIN_CLK_EN_OUT,
   output logic BKG_ACTIVE_OUT,
   output logic USER_RUN_OUT
);
   import csd_pkg::*;

   // Entire module state
   typedef struct packed {
      logic aw_got;
      logic [7:0] aw_addr;
      logic w_got;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic enbg;
      logic minclk;
      logic resetbg;
      csd_run_type run;
      logic [7:0] flags;
      csd_opreq_type opreq;
      logic [15:0] index;
      logic [15:0] stack;
      logic [15:0] ea;
      logic illegal;
      logic osc_on;
      logic core_clk;
      logic min_clk;
      logic bkg;
      logic user_run;
   } csd_state_type;

   csd_state_type cur_ff; // Registered state
   csd_state_type nxt_ff; // Next state
   csd_opres_type opres; // Decoder result

   // Operand decoder, fed from software-written request
   csd_opdec u_opdec (
      .req_in(cur_ff.opreq),
      .index_in(cur_ff.index),
      .stack_in(cur_ff.stack),
      .res_out(opres)
   );

   // Operand word view: mode, class, spare, b1, then pc_next
   // The low half doubles as b2 [15:8] and bit number [2:0]
   function automatic logic [31:0] opnd_word(input csd_opreq_type q);
      opnd_word = {q.mode, q.iclass, 2'b00, q.b1, q.pc_next};
   endfunction : opnd_word

   // Byte-lane merge of a write into an old word
   function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      lane_merge = r;
   endfunction : lane_merge

   // Eight-bit add or subtract with flag update
   function automatic logic [7:0] alu_flags(input logic [7:0] f,
                                            input logic [7:0] a,
                                            input logic [7:0] b,
                                            input logic sub);
      logic [8:0] s;
      logic [4:0] hs;
      logic [7:0] r;
      logic [7:0] bb;
      r = f;
      bb = sub ? ~b : b;
      s = {1'b0, a} + {1'b0, bb} + {8'h00, sub};
      hs = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, sub};
      r[CSD_FLAG_C_POS] = sub ? ~s[8] : s[8];
      r[CSD_FLAG_H_POS] = hs[4];
      r[CSD_FLAG_V_POS] = (a[7] == bb[7]) && (s[7] != a[7]);
      r[CSD_FLAG_N_POS] = s[7];
      r[CSD_FLAG_Z_POS] = s[7:0] == 8'h00;
      alu_flags = r;
   endfunction : alu_flags

   // Next-state logic
   always_comb begin
      logic [31:0] wv;
      logic [31:0] rv;
      logic resume;
      wv = '0;
      rv = '0;
      resume = 1'b0;
      nxt_ff = cur_ff;
      // Write address and data taken in either order
      if (cur_ff.awready && AWVALID_IN) begin
         nxt_ff.aw_got = 1'b1;
         nxt_ff.aw_addr = AWADDR_IN;
      end
      if (cur_ff.wready && WVALID_IN) begin
         nxt_ff.w_got = 1'b1;
         nxt_ff.w_data = WDATA_IN;
         nxt_ff.w_strb = WSTRB_IN;
      end
      nxt_ff.awready = !nxt_ff.aw_got && !cur_ff.bvalid;
      nxt_ff.wready = !nxt_ff.w_got && !cur_ff.bvalid;
      if (cur_ff.bvalid && BREADY_IN) begin
         nxt_ff.bvalid = 1'b0;
         nxt_ff.awready = 1'b1;
         nxt_ff.wready = 1'b1;
      end
      // Register write once both halves are held
      if (cur_ff.aw_got && cur_ff.w_got && !cur_ff.bvalid) begin
         nxt_ff.aw_got = 1'b0;
         nxt_ff.w_got = 1'b0;
         nxt_ff.bvalid = 1'b1;
         nxt_ff.bresp = CSD_RESP_OK;
         if (cur_ff.aw_addr == CSD_CTRL_OFS) begin
            wv = lane_merge('0, cur_ff.w_data, cur_ff.w_strb);
            nxt_ff.minclk = wv[CSD_CTRL_MINCLK_POS];
            nxt_ff.resetbg = wv[CSD_CTRL_RESETBG_POS];
            if (wv[CSD_CTRL_ENBG_POS]) begin
               nxt_ff.enbg = 1'b1;
            end
         end else if (cur_ff.aw_addr == CSD_FLAGS_OFS) begin
            if (cur_ff.w_strb[0]) begin
               nxt_ff.flags = cur_ff.w_data[7:0];
            end
         end else if (cur_ff.aw_addr == CSD_OPND_OFS) begin
            // b1 has its own bits and is fully writable; b2, pc_next and bitn share the low half
            wv = lane_merge(opnd_word(cur_ff.opreq), cur_ff.w_data,
                            cur_ff.w_strb);
            nxt_ff.opreq.mode = csd_mode_type'(wv[31:28]);
            nxt_ff.opreq.iclass = csd_iclass_type'(wv[27:26]);
            nxt_ff.opreq.b1 = wv[23:16];
            nxt_ff.opreq.b2 = wv[15:8];
            nxt_ff.opreq.pc_next = wv[15:0];
            nxt_ff.opreq.bitn = wv[2:0];
         end else if (cur_ff.aw_addr == CSD_BASE_OFS) begin
            wv = lane_merge({cur_ff.stack, cur_ff.index},
                            cur_ff.w_data, cur_ff.w_strb);
            nxt_ff.index = wv[15:0];
            nxt_ff.stack = wv[31:16];
         end else if (cur_ff.aw_addr == CSD_EA_OFS) begin
            // Strobe: latch decoded address, apply post-increment
            nxt_ff.ea = opres.ea;
            nxt_ff.illegal = opres.illegal;
            if (opres.postinc && !opres.illegal) begin
               nxt_ff.index = cur_ff.index + CSD_ONE;
            end
         end else begin
            nxt_ff.bresp = CSD_RESP_SLVERR;
         end
      end
      // Read channel
      nxt_ff.arready = !cur_ff.rvalid && !cur_ff.arready;
      if (cur_ff.rvalid && RREADY_IN) begin
         nxt_ff.rvalid = 1'b0;
      end
      if (cur_ff.arready && ARVALID_IN) begin
         nxt_ff.arready = 1'b0;
         nxt_ff.rvalid = 1'b1;
         nxt_ff.rresp = CSD_RESP_OK;
         if (ARADDR_IN == CSD_CTRL_OFS) begin
            rv[CSD_CTRL_ENBG_POS] = cur_ff.enbg;
            rv[CSD_CTRL_MINCLK_POS] = cur_ff.minclk;
            rv[CSD_CTRL_RESETBG_POS] = cur_ff.resetbg;
         end else if (ARADDR_IN == CSD_STAT_OFS) begin
            rv[1:0] = cur_ff.run;
            rv[4] = cur_ff.osc_on;
            rv[5] = cur_ff.core_clk;
            rv[6] = cur_ff.min_clk;
            rv[7] = cur_ff.illegal;
         end else if (ARADDR_IN == CSD_FLAGS_OFS) begin
            rv[7:0] = cur_ff.flags;
         end else if (ARADDR_IN == CSD_OPND_OFS) begin
            rv = opnd_word(cur_ff.opreq);
         end else if (ARADDR_IN == CSD_BASE_OFS) begin
            rv = {cur_ff.stack, cur_ff.index};
         end else if (ARADDR_IN == CSD_EA_OFS) begin
            rv = {8'h00, opres.bitmask, cur_ff.ea};
         end else begin
            nxt_ff.rresp = CSD_RESP_SLVERR;
         end
         nxt_ff.rdata = rv;
      end
      // Flag update from arithmetic
      if (ALU_VALID_IN) begin
         nxt_ff.flags = alu_flags(cur_ff.flags, ALU_A_IN, ALU_B_IN,
                                  ALU_SUB_IN);
      end
      // Debug enable set by serial command
      if (DBG_CMD_IN == DC_SETEN) begin
         nxt_ff.enbg = 1'b1;
      end
      resume = DBG_CMD_IN == DC_GO || DBG_CMD_IN == DC_TRACE
               || DBG_CMD_IN == DC_TAG_RESUME_COMMAND;
      // Run-state machine
      case (cur_ff.run)
         RS_RUN: begin
            if (OPCODE_VALID_IN && OPCODE_IN == CSD_BACKGROUND_ENTRY_INSTRUCTION_OPC) begin
               nxt_ff.run = RS_BKG;
            end else if (DBG_CMD_IN == DC_HALT && cur_ff.enbg) begin
               nxt_ff.run = RS_BKG;
            end else if (STOP_EXEC_IN) begin
               nxt_ff.run = RS_STOP;
            end
         end
         RS_STOP: begin
            if (DBG_CMD_IN == DC_HALT && cur_ff.enbg) begin
               nxt_ff.run = RS_BKG;
            end else if (EXT_WAKE_IN
                         || (PERIODIC_WAKE_IN && cur_ff.minclk)) begin
               nxt_ff.run = RS_RUN;
            end
         end
         RS_BKG: begin
            // Only a resume command leaves background mode
            if (resume) begin
               nxt_ff.run = RS_RUN;
            end
         end
         default: nxt_ff.run = RS_RUN;
      endcase
      // Clock gating follows the next run state
      nxt_ff.bkg = nxt_ff.run == RS_BKG;
      nxt_ff.user_run = nxt_ff.run == RS_RUN;
      nxt_ff.core_clk = nxt_ff.run != RS_STOP;
      nxt_ff.osc_on = nxt_ff.run != RS_STOP || nxt_ff.enbg;
      nxt_ff.min_clk = nxt_ff.run != RS_STOP || nxt_ff.minclk
                       || nxt_ff.enbg;
   end

   // State register; reset always starts in run mode, resetbg is only stored
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_B_IN) begin
         cur_ff <= '0;
         cur_ff.flags <= CSD_FLAGS_RST;
         cur_ff.run <= RS_RUN;
         cur_ff.awready <= 1'b1;
         cur_ff.wready <= 1'b1;
         cur_ff.osc_on <= 1'b1;
         cur_ff.core_clk <= 1'b1;
         cur_ff.min_clk <= 1'b1;
         cur_ff.user_run <= 1'b1;
      end else begin
         cur_ff <= nxt_ff;
      end
   end

   // Outputs straight from state flops
   assign AWREADY_OUT = cur_ff.awready;
   assign WREADY_OUT = cur_ff.wready;
   assign BVALID_OUT = cur_ff.bvalid;
   assign BRESP_OUT = cur_ff.bresp;
   assign ARREADY_OUT = cur_ff.arready;
   assign RVALID_OUT = cur_ff.rvalid;
   assign RDATA_OUT = cur_ff.rdata;
   assign RRESP_OUT = cur_ff.rresp;
   assign OSC_ON_OUT = cur_ff.osc_on;
   assign CORE_CLK_EN_OUT = cur_ff.core_clk;
   assign MIN_CLK_EN_OUT = cur_ff.min_clk;
   assign BKG_ACTIVE_OUT = cur_ff.bkg;
   assign USER_RUN_OUT = cur_ff.user_run;
endmodule : csd_core

//--- tb/csd_core_sva.sv
// Purpose: checker for stop, background and wake behaviour of csd_core
// Assumes: one clock, synchronous active-low reset
// Notes: stop is seen at the ports as core clocks off
module csd_core_sva
   import csd_pkg::*;
(
   input wire logic SYS_CLK_IN,
   input wire logic RST_B_IN,
   input wire csd_pkg::csd_dcmd_type DBG_CMD_IN,
   input wire logic OPCODE_VALID_IN,
   input wire logic [7:0] OPCODE_IN,
   input wire logic STOP_EXEC_IN,
   input wire logic PERIODIC_WAKE_IN,
   input wire logic EXT_WAKE_IN,
   input wire logic OSC_ON_OUT,
   input wire logic CORE_CLK_EN_OUT,
   input wire logic MIN_CLK_EN_OUT,
   input wire logic BKG_ACTIVE_OUT,
   input wire logic USER_RUN_OUT
);
   default clocking cb @(posedge SYS_CLK_IN); endclocking
   default disable iff (!RST_B_IN);
   // Any of the three commands that end background
   logic leave;
   assign leave = DBG_CMD_IN inside {DC_GO, DC_TRACE, DC_TAG_RESUME_COMMAND};
   chk_bg_entry : assert property (
      USER_RUN_OUT && OPCODE_VALID_IN && OPCODE_IN == CSD_BACKGROUND_ENTRY_INSTRUCTION_OPC &&
      DBG_CMD_IN == DC_NONE && !STOP_EXEC_IN
      |=> BKG_ACTIVE_OUT && !USER_RUN_OUT) else $error("no background");
   chk_bg_stays : assert property (
      BKG_ACTIVE_OUT && !leave |=> BKG_ACTIVE_OUT && !USER_RUN_OUT)
      else $error("background left");
   chk_bg_leave : assert property (
      BKG_ACTIVE_OUT && leave |=> USER_RUN_OUT && !BKG_ACTIVE_OUT)
      else $error("resume failed");
   chk_halt_in_stop : assert property (
      !CORE_CLK_EN_OUT && OSC_ON_OUT && DBG_CMD_IN == DC_HALT
      |=> BKG_ACTIVE_OUT && CORE_CLK_EN_OUT) else $error("halt lost");
   chk_halt_refused : assert property (
      !CORE_CLK_EN_OUT && !OSC_ON_OUT && DBG_CMD_IN == DC_HALT &&
      !EXT_WAKE_IN && !PERIODIC_WAKE_IN
      |=> !BKG_ACTIVE_OUT && !CORE_CLK_EN_OUT) else $error("halt taken");
   chk_stop_entry : assert property (
      USER_RUN_OUT && STOP_EXEC_IN && !OPCODE_VALID_IN &&
      DBG_CMD_IN == DC_NONE |=> !CORE_CLK_EN_OUT && !USER_RUN_OUT)
      else $error("stop missed");
   chk_wake_gate : assert property (
      !CORE_CLK_EN_OUT && !MIN_CLK_EN_OUT && PERIODIC_WAKE_IN &&
      !EXT_WAKE_IN && DBG_CMD_IN == DC_NONE |=> !USER_RUN_OUT)
      else $error("ungated wake");
   chk_ext_wake : assert property (
      !CORE_CLK_EN_OUT && EXT_WAKE_IN && DBG_CMD_IN == DC_NONE
      |=> USER_RUN_OUT && CORE_CLK_EN_OUT && !BKG_ACTIVE_OUT)
      else $error("wake failed");
   // Main scenarios reached
   cov_bg : cover property (USER_RUN_OUT ##1 BKG_ACTIVE_OUT);
   cov_stop_halt : cover property (!CORE_CLK_EN_OUT ##1 BKG_ACTIVE_OUT);
   cov_wake : cover property (!CORE_CLK_EN_OUT ##1 USER_RUN_OUT);
endmodule : csd_core_sva
bind csd_core csd_core_sva csd_core_sva_i (.*);

//--- tb/csd_host.sv
// Purpose: host debug system issuing serial commands as pulses
// Assumes: commands already decoded from the debug pin
// Notes: one command at a time, one cycle each
module csd_host
   import csd_pkg::*;
(
   input wire logic clk_in,
   output csd_pkg::csd_dcmd_type cmd_out
);
   initial cmd_out = DC_NONE;
   // One-cycle pulse, then idle; checks follow the taking edge
   task automatic send(input csd_dcmd_type c);
      @(posedge clk_in);
      cmd_out <= c;
      @(posedge clk_in);
      cmd_out <= DC_NONE;
      #1;
   endtask : send
endmodule : csd_host

//--- tb/csd_core_tb.sv
// Purpose: self-checking bench for csd_core
// Assumes: 40 MHz clock, AXI4-Lite master tasks, host model
// Notes: top port names reused so the instance connects by name
module csd_core_tb;
   import csd_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
$display("ERROR %s exp %h got %h", n, e, g); end end
   logic SYS_CLK_IN = 0, RST_B_IN = 0;
   logic [7:0] AWADDR_IN = 0, ARADDR_IN = 0, OPCODE_IN = 0;
   logic [7:0] ALU_A_IN = 0, ALU_B_IN = 0;
   logic [31:0] WDATA_IN = 0, RDATA_OUT;
   logic [3:0] WSTRB_IN = 4'hF;
   logic AWVALID_IN = 0, WVALID_IN = 0, BREADY_IN = 0, ARVALID_IN = 0;
   logic RREADY_IN = 0, OPCODE_VALID_IN = 0, STOP_EXEC_IN = 0;
   logic PERIODIC_WAKE_IN = 0, EXT_WAKE_IN = 0, ALU_VALID_IN = 0;
   logic ALU_SUB_IN = 0;
   logic AWREADY_OUT, WREADY_OUT, BVALID_OUT, ARREADY_OUT, RVALID_OUT;
   logic OSC_ON_OUT, CORE_CLK_EN_OUT, MIN_CLK_EN_OUT, BKG_ACTIVE_OUT;
   logic USER_RUN_OUT;
   logic [1:0] BRESP_OUT, RRESP_OUT;
   csd_dcmd_type DBG_CMD_IN;
   int fail_count = 0, checks = 0, cyc = 0;
   logic [31:0] rd;
   logic [1:0] rs;
   csd_core csd_core_i (.*);
   csd_host csd_host_i (.clk_in(SYS_CLK_IN), .cmd_out(DBG_CMD_IN));
   always #12.5 SYS_CLK_IN = ~SYS_CLK_IN;
   // Hang guard, far above the few hundred cycles needed
   always @(posedge SYS_CLK_IN) begin
      cyc++;
      if (cyc == 5000) begin
         fail_count++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      if (fail_count == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : wrap_up
   // Write: both channels offered together, each dropped when taken
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      @(posedge SYS_CLK_IN);
      AWADDR_IN <= a; WDATA_IN <= d; AWVALID_IN <= 1; WVALID_IN <= 1;
      BREADY_IN <= 1;
      forever begin
         @(posedge SYS_CLK_IN);
         if (AWVALID_IN && AWREADY_OUT) AWVALID_IN <= 0;
         if (WVALID_IN && WREADY_OUT) WVALID_IN <= 0;
         if (BVALID_OUT) begin
            rs = BRESP_OUT; BREADY_IN <= 0; break;
         end
      end
   endtask : axw
   task automatic axr(input logic [7:0] a);
      @(posedge SYS_CLK_IN);
      ARADDR_IN <= a; ARVALID_IN <= 1; RREADY_IN <= 1;
      forever begin
         @(posedge SYS_CLK_IN);
         if (ARVALID_IN && ARREADY_OUT) ARVALID_IN <= 0;
         if (RVALID_OUT) begin
            rd = RDATA_OUT; rs = RRESP_OUT; RREADY_IN <= 0; break;
         end
      end
   endtask : axr
   // Core event pulse: 0 stop, 1 periodic wake, 2 external wake
   task automatic ev(input int k);
      @(posedge SYS_CLK_IN);
      case (k)
         0: STOP_EXEC_IN <= 1;
         1: PERIODIC_WAKE_IN <= 1;
         default: EXT_WAKE_IN <= 1;
      endcase
      @(posedge SYS_CLK_IN);
      STOP_EXEC_IN <= 0; PERIODIC_WAKE_IN <= 0; EXT_WAKE_IN <= 0;
      #1;
   endtask : ev
   task automatic op(input logic [7:0] v);
      @(posedge SYS_CLK_IN);
      OPCODE_VALID_IN <= 1; OPCODE_IN <= v;
      @(posedge SYS_CLK_IN);
      OPCODE_VALID_IN <= 0;
      #1;
   endtask : op
   task automatic alu(input logic [7:0] a, b, input logic s);
      @(posedge SYS_CLK_IN);
      ALU_VALID_IN <= 1; ALU_A_IN <= a; ALU_B_IN <= b; ALU_SUB_IN <= s;
      @(posedge SYS_CLK_IN);
      ALU_VALID_IN <= 0;
   endtask : alu
   // Reset values and an unmapped place
   task automatic t_reset();
      axr(CSD_STAT_OFS); `CHK("status", 8'h70, rd[7:0])
      axr(CSD_FLAGS_OFS); `CHK("flags", 8'h08, rd[7:0])
      axr(8'h1C); `CHK("rresp", CSD_RESP_SLVERR, rs)
      axw(8'h1C, 32'h0); `CHK("bresp", CSD_RESP_SLVERR, rs)
   endtask : t_reset
   // Debug disabled: oscillator halts, halt refused, only external wake restarts
   task automatic t_plain_stop();
      axw(CSD_CTRL_OFS, 32'h0);
      ev(0); `CHK("osc", 1'b0, OSC_ON_OUT)
      `CHK("core", 1'b0, CORE_CLK_EN_OUT)
      csd_host_i.send(DC_HALT); `CHK("bkg", 1'b0, BKG_ACTIVE_OUT)
      ev(1); `CHK("run", 1'b0, USER_RUN_OUT)
      ev(2); `CHK("run", 1'b1, USER_RUN_OUT)
      `CHK("bkg", 1'b0, BKG_ACTIVE_OUT)
   endtask : t_plain_stop
   task automatic t_min_wake();
      axw(CSD_CTRL_OFS, 32'h2);
      ev(0); `CHK("min", 1'b1, MIN_CLK_EN_OUT)
      ev(1); `CHK("run", 1'b1, USER_RUN_OUT)
   endtask : t_min_wake
   // Debug enabled: oscillator kept, halt in stop enters background
   task automatic t_dbg_stop();
      csd_host_i.send(DC_SETEN);
      ev(0); `CHK("osc", 1'b1, OSC_ON_OUT)
      csd_host_i.send(DC_HALT); `CHK("bkg", 1'b1, BKG_ACTIVE_OUT)
      `CHK("core", 1'b1, CORE_CLK_EN_OUT)
      ev(2); `CHK("bkg", 1'b1, BKG_ACTIVE_OUT)
      csd_host_i.send(DC_GO); `CHK("run", 1'b1, USER_RUN_OUT)
   endtask : t_dbg_stop
   // Entry opcode stops the program; each resume command restarts it
   task automatic t_background_entry_instruction();
      csd_dcmd_type cl[3] = '{DC_GO, DC_TRACE, DC_TAG_RESUME_COMMAND};
      op(8'h81); `CHK("run", 1'b1, USER_RUN_OUT)
      foreach (cl[i]) begin
         op(CSD_BACKGROUND_ENTRY_INSTRUCTION_OPC); `CHK("bkg", 1'b1, BKG_ACTIVE_OUT)
         `CHK("run", 1'b0, USER_RUN_OUT)
         csd_host_i.send(DC_HALT); `CHK("run", 1'b0, USER_RUN_OUT)
         csd_host_i.send(cl[i]); `CHK("run", 1'b1, USER_RUN_OUT)
      end
   endtask : t_background_entry_instruction
   // Flag positions and carry out of bit 7
   task automatic t_flags();
      alu(8'hFF, 8'h01, 0); axr(CSD_FLAGS_OFS);
      `CHK("flags", 8'h1B, rd[7:0])
      alu(8'h7F, 8'h01, 0); axr(CSD_FLAGS_OFS);
      `CHK("flags", 8'h9C, rd[7:0])
      alu(8'h00, 8'h01, 1); axr(CSD_FLAGS_OFS);
      `CHK("borrow", 2'b01, rd[1:0])
      axw(CSD_FLAGS_OFS, 32'h13); axr(CSD_FLAGS_OFS);
      `CHK("flags", 8'h13, rd[7:0])
   endtask : t_flags
   // Load an operand request, strobe the former, read the address back
   task automatic dec(input logic [31:0] w, input logic [15:0] e);
      axw(CSD_OPND_OFS, w);
      axw(CSD_EA_OFS, 32'h0);
      axr(CSD_EA_OFS);
      `CHK("ea", e, rd[15:0])
   endtask : dec
   // Address forming per mode, base index 0x1234, stack 0x8000
   task automatic t_opdec();
      axw(CSD_BASE_OFS, 32'h8000_1234);
      dec(32'h20A5_0005, 16'h00A5);
      `CHK("mask", 8'h20, rd[23:16])
      dec(32'h30C3_5A00, 16'hC35A);
      dec(32'h60F0_0000, 16'h1324);
      dec(32'h80FF_FE00, 16'h1232);
      dec(32'h9010_0000, 16'h8010);
      dec(32'hA001_0000, 16'h8100);
      dec(32'hB080_2000, 16'h1F80);
      dec(32'h5800_0000, 16'h1234);
      axr(CSD_BASE_OFS); `CHK("index", 16'h1235, rd[15:0])
      dec(32'h5000_0000, 16'h1235);
      axr(CSD_STAT_OFS); `CHK("illegal", 1'b1, rd[7])
      dec(32'h7802_0000, 16'h1237);
      axr(CSD_BASE_OFS); `CHK("index", 16'h1235, rd[15:0])
      dec(32'h7402_0000, 16'h1237);
      axr(CSD_STAT_OFS); `CHK("illegal", 1'b0, rd[7])
      axr(CSD_BASE_OFS); `CHK("index", 16'h1236, rd[15:0])
      axr(CSD_OPND_OFS); `CHK("opnd", 32'h7402_0000, rd)
   endtask : t_opdec
   initial begin
      repeat (3) @(posedge SYS_CLK_IN);
      RST_B_IN <= 1;
      t_reset();
      t_plain_stop();
      t_min_wake();
      t_flags();
      t_opdec();
      t_dbg_stop();
      t_background_entry_instruction();
      wrap_up();
   end
endmodule : csd_core_tb
